/* hdl/mes_statistics.sv */
/*
  Motion estimator field statistics and pan-zoom parameter registers.
  Assumes the serial control front end gives a byte address, a one-cycle
  write strobe and a one-cycle read strobe, and takes read data one cycle
  after the strobe. All video inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mes_statistics #(
  parameter int ACC_W = 32,                    // Internal accumulator width
  parameter int ACTIVE_WIDTH_W = 11,           // Width of activeWidth input
  parameter int ACTIVE_LINES_W = 10
) (
  input wire logic sys_clk,                              // 100 MHz clock
  input wire logic rst_n,                                // Async reset, active low
  input wire mes_pkg::mes_pix_t pixIn,                   // Compared pixel streams
  input wire mes_pkg::mes_blk_t blkIn,                   // Block vector results
  input wire mes_pkg::mes_field_t fieldIn,               // Field timing and modes
  input wire logic burstError,                           // Pulse per burst error
  input wire logic [ACTIVE_WIDTH_W-1:0] activeWidth,     // Pixels per line
  input wire logic [ACTIVE_LINES_W-1:0] activeLines,     // Lines per field
  input wire logic [7:0] regAddr,                        // Register byte address
  input wire logic [7:0] regWrData,                      // Write data
  input wire logic regWrEn,                              // Write strobe
  input wire logic regRdEn,                              // Read strobe
  output logic [7:0] regRdData,                          // Read data, registered
  output logic [7:0] panZoomDeltaH,                      // Horizontal delta
  output logic [7:0] panZoomStartV,                      // Vertical start
  output logic [7:0] panZoomDeltaV                       // Vertical delta
);
  import mes_pkg::*;

  // ***************************************************************
  // Helper functions
  // ***************************************************************
  // Absolute difference of two signed vector components
  function automatic logic [8:0] absDiff(input logic signed [7:0] a, input logic signed [7:0] b);
    logic signed [8:0] d;
    d = 9'(a) - 9'(b);
    absDiff = d[8] ? 9'(-d) : 9'(d);
  endfunction : absDiff

  // Squared difference of two unsigned samples
  function automatic logic [15:0] sqDiff(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = (a > b) ? (a - b) : (b - a);
    sqDiff = 16'(d) * 16'(d);
  endfunction : sqDiff

  // Clamp an accumulator to sixteen bits
  function automatic logic [15:0] clamp16(input logic [ACC_W-1:0] v);
    clamp16 = (v > ACC_W'(MES_MAX_WORD)) ? MES_MAX_WORD : v[15:0];
  endfunction : clamp16

  // Clamp an accumulator to eight bits
  function automatic logic [7:0] clamp8(input logic [ACC_W-1:0] v);
    clamp8 = (v > ACC_W'(MES_MAX_BYTE)) ? MES_MAX_BYTE : v[7:0];
  endfunction : clamp8

  // ***************************************************************
  // Measurement window
  // ***************************************************************
  logic inWindow;
  logic pixCount;
  logic [ACC_W-1:0] inErrAdd;
  logic [ACC_W-1:0] flErrAdd;

  // The window shrinks by the border on every edge of the active video
  always_comb begin
    inWindow = (ACC_W'(pixIn.xPos) >= ACC_W'(MES_BORDER_PIXELS)) &&
               (ACC_W'(pixIn.xPos) + ACC_W'(MES_BORDER_PIXELS) < ACC_W'(activeWidth)) &&
               (ACC_W'(pixIn.yPos) >= ACC_W'(MES_BORDER_LINES)) &&
               (ACC_W'(pixIn.yPos) + ACC_W'(MES_BORDER_LINES) < ACC_W'(activeLines));
    pixCount = pixIn.valid && pixIn.onNewLine && inWindow && fieldIn.deintActive;
    inErrAdd = pixCount ? ACC_W'(sqDiff(pixIn.memPix, pixIn.inPix)) : '0;
    flErrAdd = pixCount ? ACC_W'(sqDiff(pixIn.memPix, pixIn.filtPix)) : '0;
  end

  // ***************************************************************
  // Per-block vector terms
  // ***************************************************************
  logic [ACC_W-1:0] actAdd;
  logic [ACC_W-1:0] tempAdd;
  logic [ACC_W-1:0] spatAdd;
  logic [ACC_W-1:0] nbrTerm [MES_NEIGHBOURS];

  // One neighbour term each: horizontal plus vertical difference
  genvar gn;
  generate
    for (gn = 0; gn < MES_NEIGHBOURS; gn++) begin : gNbr
      always_comb begin
        nbrTerm[gn] = ACC_W'(absDiff(blkIn.prevVec.x, blkIn.prevNbr[gn].x)) +
                      ACC_W'(absDiff(blkIn.prevVec.y, blkIn.prevNbr[gn].y));
      end
    end
  endgenerate

  // Activity takes vector magnitudes so opposing motion does not cancel out
  always_comb begin
    actAdd = '0;
    tempAdd = '0;
    spatAdd = '0;
    if (blkIn.valid) begin
      actAdd = ACC_W'(absDiff(blkIn.newVec.x, 8'sh00)) +
               ACC_W'(absDiff(blkIn.newVec.y, 8'sh00));
      tempAdd = ACC_W'(absDiff(blkIn.newVec.x, blkIn.prevVec.x)) +
                ACC_W'(absDiff(blkIn.newVec.y, blkIn.prevVec.y));
      for (int i = 0; i < MES_NEIGHBOURS; i++) begin
        spatAdd = spatAdd + nbrTerm[i];
      end
    end
  end

  // ***************************************************************
  // Running accumulators
  // ***************************************************************
  logic [ACC_W-1:0] inErrAcc_r;
  logic [ACC_W-1:0] flErrAcc_r;
  logic [ACC_W-1:0] actAcc_r;
  logic [ACC_W-1:0] tempAcc_r;
  logic [ACC_W-1:0] spatAcc_r;
  logic [7:0] burstAcc_r;
  logic [ACC_W-1:0] inErrAcc_nxt;
  logic [ACC_W-1:0] flErrAcc_nxt;
  logic [ACC_W-1:0] actAcc_nxt;
  logic [ACC_W-1:0] tempAcc_nxt;
  logic [ACC_W-1:0] spatAcc_nxt;
  logic [7:0] burstAcc_nxt;

  // A field start restarts from the current sample so nothing is dropped
  always_comb begin
    inErrAcc_nxt = (fieldIn.fieldStart ? '0 : inErrAcc_r) + inErrAdd;
    flErrAcc_nxt = (fieldIn.fieldStart ? '0 : flErrAcc_r) + flErrAdd;
    actAcc_nxt = (fieldIn.fieldStart ? '0 : actAcc_r) + actAdd;
    tempAcc_nxt = (fieldIn.fieldStart ? '0 : tempAcc_r) + tempAdd;
    spatAcc_nxt = (fieldIn.fieldStart ? '0 : spatAcc_r) + spatAdd;
    burstAcc_nxt = fieldIn.fieldStart ? MES_RST_BYTE : burstAcc_r;
    if (burstError && burstAcc_nxt != MES_MAX_BYTE) begin
      burstAcc_nxt = burstAcc_nxt + 8'h01;
    end
  end

  // Accumulators; wide sums are clamped only when latched at field end and can wrap, while the burst count saturates itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inErrAcc_r <= '0;
      flErrAcc_r <= '0;
      actAcc_r <= '0;
      tempAcc_r <= '0;
      spatAcc_r <= '0;
      burstAcc_r <= MES_RST_BYTE;
    end else begin
      inErrAcc_r <= inErrAcc_nxt;
      flErrAcc_r <= flErrAcc_nxt;
      actAcc_r <= actAcc_nxt;
      tempAcc_r <= tempAcc_nxt;
      spatAcc_r <= spatAcc_nxt;
      burstAcc_r <= burstAcc_nxt;
    end
  end

  // ***************************************************************
  // Field-end result latches
  // ***************************************************************
  logic [15:0] inErrRes_r;
  logic [15:0] flErrRes_r;
  logic [15:0] actRes_r;
  logic [7:0] tempRes_r;
  logic [7:0] spatRes_r;
  logic [7:0] burstRes_r;
  logic errZero;

  // Error sums are forced to zero without de-interlacing or after a new
  // input field in field doubling mode
  assign errZero = !fieldIn.deintActive ||
                   (fieldIn.fieldDoubling && fieldIn.newInputField);

  // Whole 16-bit words latch together so both bytes belong to one field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inErrRes_r <= MES_RST_WORD;
      flErrRes_r <= MES_RST_WORD;
      actRes_r <= MES_RST_WORD;
      tempRes_r <= MES_RST_BYTE;
      spatRes_r <= MES_RST_BYTE;
      burstRes_r <= MES_RST_BYTE;
    end else if (fieldIn.fieldEnd) begin
      inErrRes_r <= errZero ? MES_RST_WORD : clamp16(inErrAcc_nxt);
      flErrRes_r <= errZero ? MES_RST_WORD : clamp16(flErrAcc_nxt);
      actRes_r <= clamp16(actAcc_nxt);
      tempRes_r <= clamp8(tempAcc_nxt);
      spatRes_r <= clamp8(spatAcc_nxt);
      burstRes_r <= burstAcc_nxt;
    end
  end

  // ***************************************************************
  // Write-only pan-zoom parameters
  // ***************************************************************
  logic [7:0] pzDeltaH_r;
  logic [7:0] pzStartV_r;
  logic [7:0] pzDeltaV_r;

  // Host-written values steer the pan-zoom candidate generator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pzDeltaH_r <= MES_RST_BYTE;
      pzStartV_r <= MES_RST_BYTE;
      pzDeltaV_r <= MES_RST_BYTE;
    end else if (regWrEn) begin
      if (regAddr == MES_OFS_PZ_DELTA_H) begin
        pzDeltaH_r <= regWrData;
      end
      if (regAddr == MES_OFS_PZ_START_V) begin
        pzStartV_r <= regWrData;
      end
      if (regAddr == MES_OFS_PZ_DELTA_V) begin
        pzDeltaV_r <= regWrData;
      end
    end
  end

  assign panZoomDeltaH = pzDeltaH_r;
  assign panZoomStartV = pzStartV_r;
  assign panZoomDeltaV = pzDeltaV_r;

  // ***************************************************************
  // Read port
  // ***************************************************************
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  // Write-only and unmapped addresses read as zero
  always_comb begin
    unique case (regAddr)
      MES_OFS_INERR_HI: rdData_nxt = inErrRes_r[MES_HI_MSB:MES_HI_LSB];
      MES_OFS_INERR_LO: rdData_nxt = inErrRes_r[MES_LO_MSB:MES_LO_LSB];
      MES_OFS_FLERR_HI: rdData_nxt = flErrRes_r[MES_HI_MSB:MES_HI_LSB];
      MES_OFS_FLERR_LO: rdData_nxt = flErrRes_r[MES_LO_MSB:MES_LO_LSB];
      MES_OFS_ACT_HI: rdData_nxt = actRes_r[MES_HI_MSB:MES_HI_LSB];
      MES_OFS_ACT_LO: rdData_nxt = actRes_r[MES_LO_MSB:MES_LO_LSB];
      MES_OFS_TEMP_CONS: rdData_nxt = tempRes_r;
      MES_OFS_SPAT_CONS: rdData_nxt = spatRes_r;
      MES_OFS_BURST_CNT: rdData_nxt = burstRes_r;
      default: rdData_nxt = MES_UNMAPPED;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= MES_RST_BYTE;
    end else if (regRdEn) begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
endmodule : mes_statistics
`default_nettype wire

/* common/mes_pkg.sv */
/*
  Shared constants and types for the motion estimator statistics block:
  register offsets, field widths, reset values and the stream carriers.
  Assumes the serial control front end presents decoded byte addresses.
*/
`default_nettype none
package mes_pkg;
  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] MES_OFS_PZ_DELTA_H = 8'h9D;
  localparam logic [7:0] MES_OFS_PZ_START_V = 8'h9E;
  localparam logic [7:0] MES_OFS_PZ_DELTA_V = 8'h9F;
  localparam logic [7:0] MES_OFS_INERR_HI = 8'hA0;
  localparam logic [7:0] MES_OFS_INERR_LO = 8'hA1;
  localparam logic [7:0] MES_OFS_FLERR_HI = 8'hA2;
  localparam logic [7:0] MES_OFS_FLERR_LO = 8'hA3;
  localparam logic [7:0] MES_OFS_ACT_HI = 8'hA4;
  localparam logic [7:0] MES_OFS_ACT_LO = 8'hA5;
  localparam logic [7:0] MES_OFS_TEMP_CONS = 8'hA6;
  localparam logic [7:0] MES_OFS_SPAT_CONS = 8'hA7;
  localparam logic [7:0] MES_OFS_BURST_CNT = 8'hA8;

  // ***************************************************************
  // Field layout, reset values and window border
  // ***************************************************************
  localparam int MES_HI_MSB = 15;
  localparam int MES_HI_LSB = 8;
  localparam int MES_LO_MSB = 7;
  localparam int MES_LO_LSB = 0;
  localparam logic [7:0] MES_RST_BYTE = 8'h00;
  localparam logic [15:0] MES_RST_WORD = 16'h0000;
  localparam logic [15:0] MES_MAX_WORD = 16'hFFFF;
  localparam logic [7:0] MES_MAX_BYTE = 8'hFF;
  localparam logic [7:0] MES_UNMAPPED = 8'h00;
  localparam int MES_BORDER_PIXELS = 40;
  localparam int MES_BORDER_LINES = 20;
  localparam int MES_POS_X_W = 11;
  localparam int MES_POS_Y_W = 10;
  localparam int MES_NEIGHBOURS = 4;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  // One luminance sample of each compared stream at one position
  typedef struct packed {
    logic valid;                      // Sample present this cycle
    logic onNewLine;                  // Line coincides with a new field line
    logic [MES_POS_X_W-1:0] xPos;     // Pixel index in the line
    logic [MES_POS_Y_W-1:0] yPos;     // Field line index
    logic [7:0] memPix;               // Vector shifted stored frame memory output
    logic [7:0] inPix;                // New field input memory sample
    logic [7:0] filtPix;              // Filtered data rewritten into memory
  } mes_pix_t;

  // Two's complement motion vector
  typedef struct packed {
    logic signed [7:0] x;
    logic signed [7:0] y;
  } mes_vec_t;

  // One block result of the estimator
  typedef struct packed {
    logic valid;                              // Block result present
    mes_vec_t newVec;                         // Newly estimated vector
    mes_vec_t prevVec;                        // Same position, previous run
    mes_vec_t [MES_NEIGHBOURS-1:0] prevNbr;   // L, R, U, D of previous run
  } mes_blk_t;

  // Field sequencing and mode flags
  typedef struct packed {
    logic fieldStart;       // Pulse: first cycle of a field
    logic fieldEnd;         // Pulse: last cycle of a field
    logic deintActive;      // De-interlacer active this field
    logic fieldDoubling;    // Field doubling mode
    logic newInputField;    // This field is a new input field
  } mes_field_t;
endpackage : mes_pkg
`default_nettype wire

/* dv/mes_statistics_monitor.sv */
/*
  Port checker for the statistics block: register access and field results.
  Bound to every mes_statistics instance; one clock domain, async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mes_statistics_monitor (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire mes_pkg::mes_field_t fieldIn, // Field timing
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWrEn, // Write strobe
  input wire logic regRdEn, // Read strobe
  input wire logic [7:0] regRdData, // Read data
  input wire logic [7:0] panZoomDeltaH, // Horizontal delta
  input wire logic [7:0] panZoomStartV, // Vertical start
  input wire logic [7:0] panZoomDeltaV // Vertical delta
);
  import mes_pkg::*;
  // ***************************************************************
  // Helper state and assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic offZ_r;
  logic dblZ_r;
  logic pzWr;
  logic errRd;
  // Reads coinciding with a field end still see the previous field's result, so skip them
  assign errRd = regRdEn && regAddr inside {[MES_OFS_INERR_HI:MES_OFS_FLERR_LO]}
    && !fieldIn.fieldEnd;
  assign pzWr = regWrEn && regAddr inside {[MES_OFS_PZ_DELTA_H:MES_OFS_PZ_DELTA_V]};
  // Why the error sums must read zero; reset values are zero as well
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      offZ_r <= 1'b1;
      dblZ_r <= 1'b1;
    end else if (fieldIn.fieldEnd) begin
      offZ_r <= !fieldIn.deintActive;
      dblZ_r <= fieldIn.fieldDoubling && fieldIn.newInputField;
    end
  end
  chk_wr_delta_h: assert property (regWrEn && regAddr == MES_OFS_PZ_DELTA_H
    |=> panZoomDeltaH == $past(regWrData)) else $error("delta h write lost");
  chk_wr_start_v: assert property (regWrEn && regAddr == MES_OFS_PZ_START_V
    |=> panZoomStartV == $past(regWrData)) else $error("start v write lost");
  chk_wr_delta_v: assert property (regWrEn && regAddr == MES_OFS_PZ_DELTA_V
    |=> panZoomDeltaV == $past(regWrData)) else $error("delta v write lost");
  chk_pz_hold: assert property (!pzWr
    |=> $stable({panZoomDeltaH, panZoomStartV, panZoomDeltaV})) else $error("pz changed");
  chk_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved");
  chk_rd_wo_zero: assert property (regRdEn && pzWr == regWrEn &&
    regAddr inside {[MES_OFS_PZ_DELTA_H:MES_OFS_PZ_DELTA_V]} |=> regRdData == MES_UNMAPPED)
    else $error("write-only read not zero");
  chk_err_off_zero: assert property (errRd && offZ_r |=> regRdData == MES_RST_BYTE)
    else $error("error sum not zero with deinterlacer off");
  chk_err_dbl_zero: assert property (errRd && dblZ_r |=> regRdData == MES_RST_BYTE)
    else $error("error sum not zero in field doubling");
  chk_stat_stable: assert property (regRdEn && !fieldIn.fieldEnd ##1 regRdEn &&
    $stable(regAddr) && !fieldIn.fieldEnd |=> $stable(regRdData)) else $error("result moved");
  cov_field_end: cover property (fieldIn.fieldEnd && fieldIn.deintActive);
  cov_pz_write: cover property (pzWr);
  cov_dbl_read: cover property (errRd && dblZ_r);
endmodule : mes_statistics_monitor
bind mes_statistics mes_statistics_monitor u_mon (.sys_clk, .rst_n, .fieldIn, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .panZoomDeltaH, .panZoomStartV, .panZoomDeltaV);
`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench for the statistics block: register access and fields.
  Drives all inputs at the falling edge; the checker is attached by bind.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mes_pkg::*;
  // ***************************************************************
  // Signals, clock, timeout
  // ***************************************************************
  logic sys_clk, rst_n, burstError, regWrEn, regRdEn;
  mes_pix_t pixIn;
  mes_blk_t blkIn;
  mes_field_t fieldIn;
  logic [10:0] activeWidth;
  logic [9:0] activeLines;
  logic [7:0] regAddr, regWrData, regRdData, panZoomDeltaH, panZoomStartV, panZoomDeltaV;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  mes_statistics u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pixIn(pixIn), .blkIn(blkIn),
    .fieldIn(fieldIn), .burstError(burstError), .activeWidth(activeWidth),
    .activeLines(activeLines), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .panZoomDeltaH(panZoomDeltaH),
    .panZoomStartV(panZoomStartV), .panZoomDeltaV(panZoomDeltaV));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // The whole run needs under a hundred cycles; a hang is cut off well past that
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ***************************************************************
  // Tasks
  // ***************************************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Strobe stays high so that reads can run back to back; idle drops it
  task rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
  endtask : wr
  task idle;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    pixIn = '0;
    @(negedge sys_clk);
  endtask : idle
  task pix(input logic [10:0] x, input logic [9:0] y, input logic nl,
    input logic [7:0] m, input logic [7:0] i, input logic [7:0] f);
    pixIn = '{1'b1, nl, x, y, m, i, f};
    @(negedge sys_clk);
  endtask : pix
  // All four neighbours get the same vector
  task blk(input mes_vec_t n, input mes_vec_t p, input mes_vec_t b);
    pixIn = '0;
    blkIn = '{1'b1, n, p, {b, b, b, b}};
    @(negedge sys_clk);
  endtask : blk
  task burst;
    blkIn = '0;
    burstError = 1'b1;
    @(negedge sys_clk);
    burstError = 1'b0;
    @(negedge sys_clk);
  endtask : burst
  task fstart(input logic d, input logic dbl, input logic ni);
    fieldIn = '{1'b1, 1'b0, d, dbl, ni};
    @(negedge sys_clk);
    fieldIn.fieldStart = 1'b0;
  endtask : fstart
  task fend;
    pixIn = '0;
    blkIn = '0;
    fieldIn.fieldEnd = 1'b1;
    @(negedge sys_clk);
    fieldIn.fieldEnd = 1'b0;
  endtask : fend
  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    {rst_n, burstError, regWrEn, regRdEn, regAddr, regWrData} = '0;
    {pixIn, blkIn, fieldIn} = '0;
    activeWidth = 11'h0C8;
    activeLines = 10'h064;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int a = 'h9D; a <= 'hA8; a++) rd(8'(a), MES_RST_BYTE);
    rd(8'hB5, MES_UNMAPPED);
    idle();
    wr(MES_OFS_PZ_DELTA_H, 8'hA5);
    wr(MES_OFS_PZ_START_V, 8'h3C);
    wr(MES_OFS_PZ_DELTA_V, 8'hC3);
    wr(MES_OFS_INERR_HI, 8'hFF);
    idle();
    chk(panZoomDeltaH, 8'hA5);
    chk(panZoomStartV, 8'h3C);
    chk(panZoomDeltaV, 8'hC3);
    rd(MES_OFS_PZ_DELTA_H, 8'h00);
    rd(MES_OFS_INERR_HI, 8'h00);
    idle();
    // Window corners count, one step beyond each edge and off-line pixels do not
    fstart(1'b1, 1'b0, 1'b0);
    pix(11'h028, 10'h014, 1'b1, 8'h0A, 8'h07, 8'h05);
    pix(11'h09F, 10'h04F, 1'b1, 8'h00, 8'h14, 8'h04);
    pix(11'h027, 10'h032, 1'b1, 8'hFF, 8'h00, 8'h00);
    pix(11'h0A0, 10'h032, 1'b1, 8'hFF, 8'h00, 8'h00);
    pix(11'h032, 10'h013, 1'b1, 8'hFF, 8'h00, 8'h00);
    pix(11'h032, 10'h050, 1'b1, 8'hFF, 8'h00, 8'h00);
    pix(11'h032, 10'h032, 1'b0, 8'hFF, 8'h00, 8'h00);
    blk(16'h03FC, 16'h0101, 16'h0002);
    blk(16'h9C9C, 16'hFF00, 16'h0200);
    repeat (3) burst();
    fend();
    rd(MES_OFS_INERR_HI, 8'h01);
    rd(MES_OFS_INERR_LO, 8'h99);
    rd(MES_OFS_FLERR_HI, 8'h00);
    rd(MES_OFS_FLERR_LO, 8'h29);
    rd(MES_OFS_ACT_HI, 8'h00);
    rd(MES_OFS_ACT_LO, 8'hCF);
    rd(MES_OFS_TEMP_CONS, 8'hCE);
    rd(MES_OFS_SPAT_CONS, 8'h14);
    rd(MES_OFS_BURST_CNT, 8'h03);
    idle();
    // De-interlacer off; the previous result must hold until the field ends
    fstart(1'b0, 1'b0, 1'b0);
    pix(11'h028, 10'h014, 1'b1, 8'h0A, 8'h07, 8'h05);
    idle();
    rd(MES_OFS_INERR_LO, 8'h99);
    rd(MES_OFS_INERR_LO, 8'h99);
    idle();
    fend();
    rd(MES_OFS_INERR_LO, 8'h00);
    rd(MES_OFS_FLERR_LO, 8'h00);
    rd(MES_OFS_ACT_LO, 8'h00);
    rd(MES_OFS_BURST_CNT, 8'h00);
    idle();
    // Field doubling: zero after a new input field, counted otherwise
    for (int k = 1; k >= 0; k--) begin
      fstart(1'b1, 1'b1, k[0]);
      pix(11'h028, 10'h014, 1'b1, 8'h0A, 8'h07, 8'h05);
      fend();
      rd(MES_OFS_INERR_LO, k[0] ? 8'h00 : 8'h09);
      rd(MES_OFS_FLERR_LO, k[0] ? 8'h00 : 8'h19);
      idle();
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
